// file: core/gpcde_consts.svh
// Overview of operation
// - usb-shared inputs readable only when usb off
// - unimplemented third-port bits read as zero
// - fourth port: eight independently directed pins
// - direction one: driver off, pin input
// - direction zero: pin driven from latch
// - latch register reads back latched value
// - fourth port inputs after reset
// - small package omits fourth port entirely
// - fifth port four bits, three bidirectional
// - analog-selected fifth pins read zero
// - direction still drives analog-selected pins
// - lower fifth pins analog after reset
// - config clear: shared pin plain input
// - config set: shared pin is master clear
// - shared pin always programming voltage sense
`ifndef GPCDE_CONSTS_SVH
`define GPCDE_CONSTS_SVH

`define GPCDE_OFS_C_PINS 8'h00
`define GPCDE_OFS_C_LAT 8'h04
`define GPCDE_OFS_C_DIR 8'h08
`define GPCDE_OFS_USB_CTL 8'h0C
`define GPCDE_OFS_D_PINS 8'h10
`define GPCDE_OFS_D_LAT 8'h14
`define GPCDE_OFS_D_DIR 8'h18
`define GPCDE_OFS_E_PINS 8'h1C
`define GPCDE_OFS_E_LAT 8'h20
`define GPCDE_OFS_E_DIR 8'h24
`define GPCDE_OFS_ANA_CFG 8'h28
`define GPCDE_OFS_STATUS 8'h2C

`define GPCDE_C_IMPL_MASK 8'hC7
`define GPCDE_C_USB_MASK 8'h30
`define GPCDE_E_IMPL_MASK 8'h07
`define GPCDE_E_SHARED_BIT 3
`define GPCDE_USB_CTL_MASK 8'h7E
`define GPCDE_USB_EN_BIT 3
`define GPCDE_ANA_CFG_MASK 8'h07

`define GPCDE_DIR_RST 8'hFF
`define GPCDE_LAT_RST 8'h00
`define GPCDE_USB_CTL_RST 8'h00
`define GPCDE_ANA_CFG_RST 8'h07

`endif

// file: core/gpcde_pkg.sv
`default_nettype none
package gpcde_pkg;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} gpcde_drive_t;

	typedef struct packed {
		logic [7:0] c_lat;
		logic [7:0] c_dir;
		logic [7:0] d_lat;
		logic [7:0] d_dir;
		logic [7:0] e_lat;
		logic [7:0] e_dir;
		logic [7:0] usb_ctl;
		logic [7:0] ana_cfg;
		logic [7:0] c_pins;
		logic [7:0] d_pins;
		logic [7:0] e_pins;
		logic small_pkg;
		logic master_clear_input_cfg;
		logic [31:0] rdata;
		logic slverr;
	} gpcde_state_t;

endpackage : gpcde_pkg
`default_nettype wire

// file: core/gpcde_top.sv
// The register offsets and the APB slave port were left to the implementer.
`include "gpcde_consts.svh"
`default_nettype none
module gpcde_top (
	input wire logic mclk_i, // system clock
	input wire logic sys_rst_i, // sync reset, high
	input wire logic small_package_i, // 28-pin strap, caught in reset
	input wire logic master_clear_config_i, // master clear config, caught in reset
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb write
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error
	input wire logic [7:0] third_port_in_i, // third port pin levels
	output gpcde_pkg::gpcde_drive_t third_port_o, // third port drive
	input wire logic [7:0] fourth_port_in_i, // fourth port pin levels
	output gpcde_pkg::gpcde_drive_t fourth_port_o, // fourth port drive
	input wire logic [3:0] fifth_port_in_i, // fifth port pin levels
	output gpcde_pkg::gpcde_drive_t fifth_port_o, // fifth port drive
	output logic master_clear_input_n_o, // master clear, low active
	output logic prog_voltage_sense_o // programming voltage sense
);

	gpcde_pkg::gpcde_state_t s_q;
	gpcde_pkg::gpcde_state_t s_d;

	function automatic gpcde_pkg::gpcde_drive_t drive(input logic [7:0] lat,
			input logic [7:0] dir, input logic [7:0] mask);
		gpcde_pkg::gpcde_drive_t r;
		r.out = lat & mask;
		r.oe = ~dir & mask;
		return r;
	endfunction : drive

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
			input logic [7:0] mask);
		return (old & ~mask) | (wr & mask);
	endfunction : merge

	logic usb_on;
	logic [7:0] c_rd_mask;
	logic [7:0] d_mask;
	logic [7:0] e_mask;
	logic [7:0] e_pins_view;
	logic [7:0] rd;
	logic hit;
	logic wr_acc;
	logic [7:0] wv;

	assign usb_on = s_q.usb_ctl[`GPCDE_USB_EN_BIT];
	assign d_mask = s_q.small_pkg ? 8'h00 : 8'hFF;
	assign e_mask = s_q.small_pkg ? 8'h00 : `GPCDE_E_IMPL_MASK;
	// usb-shared pins join the readable set only with the engine off
	assign c_rd_mask = `GPCDE_C_IMPL_MASK | (usb_on ? 8'h00 : `GPCDE_C_USB_MASK);

	always_comb
	begin
		e_pins_view = s_q.e_pins & e_mask & ~s_q.ana_cfg;
		e_pins_view[`GPCDE_E_SHARED_BIT] = ~s_q.master_clear_input_cfg
			& s_q.e_pins[`GPCDE_E_SHARED_BIT];
	end

	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign wv = pwdata_i[7:0];

	always_comb
	begin
		hit = 1'b1;
		rd = 8'h00;
		unique case (paddr_i)
			`GPCDE_OFS_C_PINS: rd = s_q.c_pins & c_rd_mask;
			`GPCDE_OFS_C_LAT: rd = s_q.c_lat;
			`GPCDE_OFS_C_DIR: rd = s_q.c_dir;
			`GPCDE_OFS_USB_CTL: rd = s_q.usb_ctl;
			`GPCDE_OFS_D_PINS: rd = s_q.d_pins & d_mask;
			`GPCDE_OFS_D_LAT: rd = s_q.d_lat;
			`GPCDE_OFS_D_DIR: rd = s_q.d_dir;
			`GPCDE_OFS_E_PINS: rd = e_pins_view;
			`GPCDE_OFS_E_LAT: rd = s_q.e_lat;
			`GPCDE_OFS_E_DIR: rd = s_q.e_dir;
			`GPCDE_OFS_ANA_CFG: rd = s_q.ana_cfg;
			`GPCDE_OFS_STATUS: rd = {6'h00, s_q.master_clear_input_cfg, s_q.small_pkg};
			default: hit = 1'b0;
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		// pins sampled once; read path sees the registered copy
		s_d.c_pins = third_port_in_i;
		s_d.d_pins = fourth_port_in_i;
		s_d.e_pins = {4'h0, fifth_port_in_i};
		if (psel_i && !penable_i)
		begin
			s_d.rdata = {24'h000000, rd};
			s_d.slverr = ~hit;
		end
		if (wr_acc)
		begin
			unique case (paddr_i)
				// a port write lands in the latch
				`GPCDE_OFS_C_PINS,
				`GPCDE_OFS_C_LAT: s_d.c_lat = merge(s_q.c_lat, wv, `GPCDE_C_IMPL_MASK);
				`GPCDE_OFS_C_DIR: s_d.c_dir = merge(s_q.c_dir, wv, `GPCDE_C_IMPL_MASK);
				`GPCDE_OFS_USB_CTL: s_d.usb_ctl = wv & `GPCDE_USB_CTL_MASK;
				`GPCDE_OFS_D_PINS,
				`GPCDE_OFS_D_LAT: s_d.d_lat = merge(s_q.d_lat, wv, d_mask);
				`GPCDE_OFS_D_DIR: s_d.d_dir = merge(s_q.d_dir, wv, d_mask);
				`GPCDE_OFS_E_PINS,
				`GPCDE_OFS_E_LAT: s_d.e_lat = merge(s_q.e_lat, wv, e_mask);
				`GPCDE_OFS_E_DIR: s_d.e_dir = merge(s_q.e_dir, wv, e_mask);
				`GPCDE_OFS_ANA_CFG: s_d.ana_cfg = wv & `GPCDE_ANA_CFG_MASK;
				default: s_d.slverr = 1'b1;
			endcase
		end
		if (sys_rst_i)
		begin
			s_d.c_lat = `GPCDE_LAT_RST;
			s_d.c_dir = `GPCDE_DIR_RST & `GPCDE_C_IMPL_MASK;
			s_d.d_lat = `GPCDE_LAT_RST;
			s_d.d_dir = `GPCDE_DIR_RST & (small_package_i ? 8'h00 : 8'hFF);
			s_d.e_lat = `GPCDE_LAT_RST;
			s_d.e_dir = `GPCDE_DIR_RST & (small_package_i ? 8'h00 : `GPCDE_E_IMPL_MASK);
			s_d.usb_ctl = `GPCDE_USB_CTL_RST;
			s_d.ana_cfg = `GPCDE_ANA_CFG_RST;
			s_d.c_pins = 8'h00;
			s_d.d_pins = 8'h00;
			s_d.e_pins = 8'h00;
			s_d.small_pkg = small_package_i;
			s_d.master_clear_input_cfg = master_clear_config_i;
			s_d.rdata = 32'h00000000;
			s_d.slverr = 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		s_q <= s_d;
	end

	assign prdata_o = s_q.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & s_q.slverr;

	// usb-shared bits have no direction bit and never drive
	assign third_port_o = drive(s_q.c_lat, s_q.c_dir, `GPCDE_C_IMPL_MASK);
	assign fourth_port_o = drive(s_q.d_lat, s_q.d_dir, d_mask);
	// direction ignores the analog selection on purpose
	assign fifth_port_o = drive(s_q.e_lat, s_q.e_dir, e_mask);

	assign master_clear_input_n_o = s_q.master_clear_input_cfg ? fifth_port_in_i[3] : 1'b1;
	assign prog_voltage_sense_o = fifth_port_in_i[3];

endmodule : gpcde_top
`default_nettype wire

// file: sim/gpcde_pins.sv
`default_nettype none
module gpcde_pins (
	input wire gpcde_pkg::gpcde_drive_t drv_c_i, // third drive
	input wire gpcde_pkg::gpcde_drive_t drv_d_i, // fourth drive
	input wire gpcde_pkg::gpcde_drive_t drv_e_i, // fifth drive
	input wire logic [23:0] ext_i, // board levels
	output logic [23:0] lvl_o // wire levels
);
	timeunit 1ns;
	timeprecision 1ns;
	assign lvl_o[7:0] = (drv_c_i.out & drv_c_i.oe) | (ext_i[7:0] & ~drv_c_i.oe);
	assign lvl_o[15:8] = (drv_d_i.out & drv_d_i.oe) | (ext_i[15:8] & ~drv_d_i.oe);
	assign lvl_o[23:16] = (drv_e_i.out & drv_e_i.oe) | (ext_i[23:16] & ~drv_e_i.oe);
endmodule : gpcde_pins
`default_nettype wire

// file: sim/gpcde_properties.sv
`include "gpcde_consts.svh"
`default_nettype none
module gpcde_props (
	input wire logic mclk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic small_package_i, // strap
	input wire logic psel_i, // apb
	input wire logic penable_i, // apb
	input wire logic pwrite_i, // apb
	input wire logic [7:0] paddr_i, // apb
	input wire logic [31:0] pwdata_i, // apb
	input wire gpcde_pkg::gpcde_drive_t third_port_o, // drive
	input wire gpcde_pkg::gpcde_drive_t fourth_port_o, // drive
	input wire gpcde_pkg::gpcde_drive_t fifth_port_o, // drive
	input wire logic [3:0] fifth_port_in_i, // pins
	input wire logic prog_voltage_sense_o // sense
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	wire wr = psel_i && penable_i && pwrite_i && !small_package_i;
	wire [7:0] wd = pwdata_i[7:0];
	AST_RST_OE:
		assert property ($past(sys_rst_i) |-> {third_port_o.oe, fourth_port_o.oe,
			fifth_port_o.oe} == 24'h000000) else $error("driver on after reset");
	AST_C_UNIMP:
		assert property (third_port_o[13:11] == 3'h0 && third_port_o[5:3] == 3'h0)
			else $error("third port gap driven");
	AST_E_UNIMP:
		assert property (fifth_port_o.oe[7:3] == 5'h00) else $error("fifth port gap driven");
	AST_D_DIR:
		assert property (wr && paddr_i == `GPCDE_OFS_D_DIR |=> fourth_port_o.oe == ~$past(wd))
			else $error("fourth enable wrong");
	AST_D_LAT:
		assert property (wr && paddr_i == `GPCDE_OFS_D_LAT |=> fourth_port_o.out == $past(wd))
			else $error("fourth value wrong");
	AST_E_DIR:
		assert property (wr && paddr_i == `GPCDE_OFS_E_DIR |=>
			fifth_port_o.oe == (~$past(wd) & 8'h07)) else $error("fifth enable wrong");
	AST_SMALL:
		assert property (small_package_i |-> fourth_port_o == 16'h0000 && fifth_port_o == 16'h0000)
			else $error("small package drives");
	AST_PROG:
		assert property (prog_voltage_sense_o == fifth_port_in_i[3]) else $error("sense wrong");
endmodule : gpcde_props
bind gpcde_top gpcde_props gpcde_props_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
	.small_package_i(small_package_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.third_port_o(third_port_o), .fourth_port_o(fourth_port_o), .fifth_port_o(fifth_port_o),
	.fifth_port_in_i(fifth_port_in_i), .prog_voltage_sense_o(prog_voltage_sense_o));
`default_nettype wire

// file: sim/gpio_ports_c_d_e_tb.sv
`include "gpcde_consts.svh"
`default_nettype none
module gpio_ports_c_d_e_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, sml = 1'b0, mcf = 1'b0, psel_i = 1'b0;
	logic penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, mcn, pvs, se;
	logic [7:0] paddr_i = 8'h00;
	logic [23:0] ext = 24'h0F3CFF, lvl;
	logic [31:0] pwdata_i = 32'h0, prdata_o, r;
	gpcde_pkg::gpcde_drive_t c_drv, d_drv, e_drv;
	int error_cnt = 0, cmp_count = 0;
	gpcde_top gpcde_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .small_package_i(sml),
		.master_clear_config_i(mcf), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .third_port_in_i(lvl[7:0]),
		.third_port_o(c_drv), .fourth_port_in_i(lvl[15:8]), .fourth_port_o(d_drv),
		.fifth_port_in_i(lvl[19:16]), .fifth_port_o(e_drv), .master_clear_input_n_o(mcn),
		.prog_voltage_sense_o(pvs));
	gpcde_pins gpcde_pins_inst (.drv_c_i(c_drv), .drv_d_i(d_drv), .drv_e_i(e_drv),
		.ext_i(ext), .lvl_o(lvl));
	initial
		forever #25 mclk_i = ~mclk_i;
	task automatic close_out();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge mclk_i);
			if (pready_o === 1'b1)
				break;
		end
		r = prdata_o;
		se = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1)
		begin
			error_cnt++;
			close_out();
		end
		@(posedge mclk_i);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd
	initial
	begin
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rd(`GPCDE_OFS_C_DIR, 32'hC7);
		chk({31'h0, se}, 32'h0);
		chk({30'h0, mcn, pvs}, 32'h3);
		rd(`GPCDE_OFS_D_DIR, 32'hFF);
		rd(`GPCDE_OFS_E_DIR, 32'h07);
		rd(`GPCDE_OFS_ANA_CFG, 32'h07);
		rd(`GPCDE_OFS_E_PINS, 32'h08);
		rd(`GPCDE_OFS_C_PINS, 32'hF7);
		$display("reset test done");
		apb(1'b1, `GPCDE_OFS_USB_CTL, 32'h08);
		rd(`GPCDE_OFS_C_PINS, 32'hC7);
		apb(1'b1, `GPCDE_OFS_C_DIR, 32'h00);
		apb(1'b1, `GPCDE_OFS_C_LAT, 32'hFF);
		chk({16'h0, c_drv}, 32'hC7C7);
		apb(1'b1, `GPCDE_OFS_ANA_CFG, 32'h00);
		rd(`GPCDE_OFS_E_PINS, 32'h0F);
		apb(1'b1, `GPCDE_OFS_D_DIR, 32'h0F);
		apb(1'b1, `GPCDE_OFS_D_LAT, 32'hA5);
		repeat (3) @(posedge mclk_i);
		rd(`GPCDE_OFS_D_PINS, 32'hAC);
		rd(`GPCDE_OFS_D_LAT, 32'hA5);
		apb(1'b1, `GPCDE_OFS_D_PINS, 32'h5A);
		rd(`GPCDE_OFS_D_LAT, 32'h5A);
		apb(1'b1, `GPCDE_OFS_E_DIR, 32'h00);
		apb(1'b1, `GPCDE_OFS_ANA_CFG, 32'h07);
		@(posedge mclk_i);
		chk({24'h0, e_drv.oe}, 32'h07);
		rd(`GPCDE_OFS_E_PINS, 32'h08);
		apb(1'b1, `GPCDE_OFS_E_DIR, 32'h07);
		chk({24'h0, e_drv.oe}, 32'h0);
		rd(8'h30, 32'h0);
		chk({31'h0, se}, 32'h1);
		$display("port test done");
		sys_rst_i <= 1'b1;
		sml <= 1'b1;
		mcf <= 1'b1;
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rd(`GPCDE_OFS_D_DIR, 32'h0);
		apb(1'b1, `GPCDE_OFS_D_LAT, 32'hFF);
		rd(`GPCDE_OFS_D_LAT, 32'h0);
		rd(`GPCDE_OFS_E_PINS, 32'h0);
		ext <= 24'h073CFF;
		@(posedge mclk_i);
		chk({30'h0, mcn, pvs}, 32'h0);
		$display("package test done");
		close_out();
	end
endmodule : gpio_ports_c_d_e_tb
`default_nettype wire
